//--- rtl/adc_frontend_pkg.sv
// Purpose: Shared constants and types for the front-end range and mux control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on the device's own register port.
package adc_frontend_pkg;

	localparam logic [7:0] OFS_OVR_A_FIRST = 8'h08;
	localparam logic [7:0] OFS_OVR_B_FIRST = 8'h09;
	localparam logic [7:0] OFS_OVR_A_SECOND = 8'h0A;
	localparam logic [7:0] OFS_OVR_B_SECOND = 8'h0B;
	localparam logic [7:0] OFS_RANGE_A = 8'h04;
	localparam logic [7:0] OFS_RANGE_B = 8'h05;
	localparam logic [7:0] OFS_RANGE_A_HI = 8'h06;
	localparam logic [7:0] OFS_RANGE_B_HI = 8'h07;
	localparam logic [7:0] OFS_CHANNEL = 8'h03;
	localparam logic [7:0] OFS_CONFIG = 8'h02;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	localparam logic [7:0] RST_OVR = 8'h00;
	localparam logic [7:0] RST_RANGE = 8'hFF;
	localparam logic [7:0] RST_CHANNEL = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;

	localparam int CFG_FILTER_LSB = 0;
	localparam int CFG_SEQ_BIT = 2;
	localparam int CFG_BURST_BIT = 3;
	localparam int CH_A_LSB = 0;
	localparam int CH_B_LSB = 4;
	localparam int CH_DIAG_A_BIT = 3;
	localparam int CH_DIAG_B_BIT = 7;

	// Extra settling for filter option two after a range change
	localparam int SETTLE_US = 120;
	localparam int CLOCK_MHZ = 125;
	localparam int SETTLE_CYCLES = SETTLE_US * CLOCK_MHZ;

	typedef enum logic [1:0] {
		RANGE_2V5 = 2'b00,
		RANGE_5V = 2'b01,
		RANGE_10V = 2'b10
	} range_t;

	typedef enum logic [1:0] {
		FILTER_ONE = 2'b00,
		FILTER_TWO = 2'b01,
		FILTER_THREE = 2'b10
	} filter_t;

	typedef enum logic [1:0] {
		RANGE_PINS_SOFT = 2'b00,
		RANGE_PINS_2V5 = 2'b01,
		RANGE_PINS_5V = 2'b10,
		RANGE_PINS_10V = 2'b11
	} range_pins_t;

	// Per-channel effective range: base code plus 20 percent widen flag
	typedef struct packed {
		logic overrange;
		range_t range;
	} chan_range_t;

	// Mux selection for one converter: diag picks the internal node input
	typedef struct packed {
		logic diag;
		logic diagNode;
		logic [2:0] channel;
	} mux_sel_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01
	} conv_state_t;

endpackage

//--- rtl/adc_frontend_range_mux_control.sv
// Purpose: Range decode, overrange, filter option and channel-pair mux control.
// Assumes: Pins are synchronous to mclk; host keeps paired registers identical.
// Notes: Range codes per channel are 2 bits, four channels per range register.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] Range pins 00 use software ranges; 01,10,11 force 2.5,5,10 V all channels.
// [R2] Software mode gives every channel its own programmed range.
// [R3] Group A overrange bits sit in two registers; host writes both identically.
// [R4] Group B overrange bits sit in two registers; host writes both identically.
// [R5] A set overrange bit widens that channel's range by twenty percent.
// [R6] Overrange applies only in software mode, never to pin-selected ranges.
// [R7] Range pin changes act at once; filter two needs 120 us settling.
// [R8] Filter field codes 00,01,10 select filter options one, two, three.
// [R9] Filter option is programmable only in software mode.
// [R10] Hardware mode captures channel pins at reset release as first pair.
// [R11] Hardware mode samples channel pins each conversion for the next pair.
// [R12] Diagnostic channels cannot be selected in hardware mode.
// [R13] Software mode takes the mux selection from a register field.
// [R14] Each mux has nine inputs: eight channels plus a two-input diagnostic mux.
// [R15] Sequencer and burst enables work in both hardware and software modes.
// [R16] Hardware mode pairs A n with B n; software pairs any A with any B.
module adc_frontend_range_mux_control #(
	parameter int SETTLE_COUNT = adc_frontend_pkg::SETTLE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] rangeSelectPins,
	input wire logic [2:0] channelPairSelectPins,
	input wire logic convStart,
	input wire logic convDone,
	input wire adc_frontend_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	output logic regAck,
	output logic softwareMode,
	output adc_frontend_pkg::chan_range_t [7:0] groupARange,
	output adc_frontend_pkg::chan_range_t [7:0] groupBRange,
	output adc_frontend_pkg::filter_t filterOption,
	output adc_frontend_pkg::mux_sel_t muxA,
	output adc_frontend_pkg::mux_sel_t muxB,
	output logic sequencerEnable,
	output logic burstEnable,
	output logic settling,
	output logic converting
);

	// Refused at elaboration: a zero count would leave the settle counter zero bits wide
	if (SETTLE_COUNT < 1) begin : g_bad_settle
		$error("SETTLE_COUNT must be at least one");
	end

	localparam int CNT_W = $clog2(SETTLE_COUNT + 1);

	logic [7:0] ovrAFirst;
	logic [7:0] ovrASecond;
	logic [7:0] ovrBFirst;
	logic [7:0] ovrBSecond;
	logic [7:0] rangeA;
	logic [7:0] rangeAHi;
	logic [7:0] rangeB;
	logic [7:0] rangeBHi;
	logic [7:0] channelReg;
	logic [7:0] configReg;
	logic [1:0] prevPins;
	logic inReset;
	logic [2:0] pendingPair;
	logic [CNT_W-1:0] settleCount;
	adc_frontend_pkg::conv_state_t convState;

	logic softNow;
	logic pinsChanged;
	adc_frontend_pkg::range_t pinRange;

	// Reserved code 11 falls back to the narrowest range to stay safe
	function automatic adc_frontend_pkg::range_t decode_range(input logic [1:0] code);
		case (code)
			2'b01: decode_range = adc_frontend_pkg::RANGE_5V;
			2'b10: decode_range = adc_frontend_pkg::RANGE_10V;
			default: decode_range = adc_frontend_pkg::RANGE_2V5;
		endcase
	endfunction

	function automatic adc_frontend_pkg::filter_t decode_filter(input logic [1:0] code);
		case (code)
			2'b00: decode_filter = adc_frontend_pkg::FILTER_ONE; // [R8]
			2'b01: decode_filter = adc_frontend_pkg::FILTER_TWO; // [R8]
			2'b10: decode_filter = adc_frontend_pkg::FILTER_THREE; // [R8]
			default: decode_filter = adc_frontend_pkg::FILTER_ONE;
		endcase
	endfunction

	always_comb begin
		softNow = (rangeSelectPins == adc_frontend_pkg::RANGE_PINS_SOFT); // [R1]
		pinsChanged = (rangeSelectPins != prevPins);
		case (rangeSelectPins)
			adc_frontend_pkg::RANGE_PINS_5V: pinRange = adc_frontend_pkg::RANGE_5V; // [R1]
			adc_frontend_pkg::RANGE_PINS_10V: pinRange = adc_frontend_pkg::RANGE_10V; // [R1]
			default: pinRange = adc_frontend_pkg::RANGE_2V5; // [R1]
		endcase
	end

	// Register writes; paired overrange registers are stored separately
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovrAFirst <= adc_frontend_pkg::RST_OVR;
			ovrASecond <= adc_frontend_pkg::RST_OVR;
			ovrBFirst <= adc_frontend_pkg::RST_OVR;
			ovrBSecond <= adc_frontend_pkg::RST_OVR;
			rangeA <= adc_frontend_pkg::RST_RANGE;
			rangeAHi <= adc_frontend_pkg::RST_RANGE;
			rangeB <= adc_frontend_pkg::RST_RANGE;
			rangeBHi <= adc_frontend_pkg::RST_RANGE;
			channelReg <= adc_frontend_pkg::RST_CHANNEL;
			configReg <= adc_frontend_pkg::RST_CONFIG;
		end else if (regReq.write) begin
			if (regReq.addr == adc_frontend_pkg::OFS_OVR_A_FIRST) begin
				ovrAFirst <= regReq.wdata; // [R3]
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_A_SECOND) begin
				ovrASecond <= regReq.wdata; // [R3]
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_B_FIRST) begin
				ovrBFirst <= regReq.wdata; // [R4]
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_B_SECOND) begin
				ovrBSecond <= regReq.wdata; // [R4]
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_A) begin
				rangeA <= regReq.wdata;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_A_HI) begin
				rangeAHi <= regReq.wdata;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_B) begin
				rangeB <= regReq.wdata;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_B_HI) begin
				rangeBHi <= regReq.wdata;
			end else if (regReq.addr == adc_frontend_pkg::OFS_CHANNEL) begin
				channelReg <= regReq.wdata; // [R13]
			end else if (regReq.addr == adc_frontend_pkg::OFS_CONFIG) begin
				configReg <= regReq.wdata;
			end
		end
	end

	// Register reads; unmapped addresses answer zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata <= 8'h00;
			regAck <= 1'b0;
		end else begin
			regAck <= regReq.read | regReq.write;
			if (!regReq.read) begin
				regRdata <= 8'h00;
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_A_FIRST) begin
				regRdata <= ovrAFirst;
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_A_SECOND) begin
				regRdata <= ovrASecond;
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_B_FIRST) begin
				regRdata <= ovrBFirst;
			end else if (regReq.addr == adc_frontend_pkg::OFS_OVR_B_SECOND) begin
				regRdata <= ovrBSecond;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_A) begin
				regRdata <= rangeA;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_A_HI) begin
				regRdata <= rangeAHi;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_B) begin
				regRdata <= rangeB;
			end else if (regReq.addr == adc_frontend_pkg::OFS_RANGE_B_HI) begin
				regRdata <= rangeBHi;
			end else if (regReq.addr == adc_frontend_pkg::OFS_CHANNEL) begin
				regRdata <= channelReg;
			end else if (regReq.addr == adc_frontend_pkg::OFS_CONFIG) begin
				regRdata <= configReg;
			end else if (regReq.addr == adc_frontend_pkg::OFS_STATUS) begin
				regRdata <= {4'h0, converting, settling, filterOption == adc_frontend_pkg::FILTER_TWO,
					softwareMode};
			end else begin
				regRdata <= 8'h00;
			end
		end
	end

	// Range outputs follow the pins in the very next cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			softwareMode <= 1'b0;
			groupARange <= '0;
			groupBRange <= '0;
		end else begin
			softwareMode <= softNow;
			for (int i = 0; i < 8; i++) begin
				if (softNow) begin
					// Each channel takes its own two-bit code and overrange bit
					groupARange[i].range <= decode_range(i < 4 ? rangeA[2*(i%4) +: 2]
						: rangeAHi[2*(i%4) +: 2]); // [R2]
					groupBRange[i].range <= decode_range(i < 4 ? rangeB[2*(i%4) +: 2]
						: rangeBHi[2*(i%4) +: 2]); // [R2]
					groupARange[i].overrange <= ovrAFirst[i]; // [R5] [R6] [R3]
					groupBRange[i].overrange <= ovrBFirst[i]; // [R5] [R6] [R4]
				end else begin
					groupARange[i].range <= pinRange; // [R1] [R7]
					groupBRange[i].range <= pinRange; // [R1] [R7]
					groupARange[i].overrange <= 1'b0; // [R6]
					groupBRange[i].overrange <= 1'b0; // [R6]
				end
			end
		end
	end

	// Filter and sequencing configuration
	always_ff @(posedge mclk) begin
		if (rst) begin
			filterOption <= adc_frontend_pkg::FILTER_ONE;
			sequencerEnable <= 1'b0;
			burstEnable <= 1'b0;
		end else begin
			if (softNow) begin
				filterOption <= decode_filter(configReg[adc_frontend_pkg::CFG_FILTER_LSB +: 2]); // [R9]
			end else begin
				filterOption <= adc_frontend_pkg::FILTER_ONE; // [R9]
			end
			sequencerEnable <= configReg[adc_frontend_pkg::CFG_SEQ_BIT]; // [R15]
			burstEnable <= configReg[adc_frontend_pkg::CFG_BURST_BIT]; // [R15]
		end
	end

	// Settling flag: a range pin change under filter two blocks sample use
	always_ff @(posedge mclk) begin
		if (rst) begin
			prevPins <= 2'b00;
			settleCount <= '0;
			settling <= 1'b0;
		end else begin
			prevPins <= rangeSelectPins;
			if (pinsChanged && filterOption == adc_frontend_pkg::FILTER_TWO) begin
				settleCount <= CNT_W'(SETTLE_COUNT); // [R7]
				settling <= 1'b1;
			end else if (settleCount != '0) begin
				settleCount <= settleCount - 1'b1;
				settling <= (settleCount != CNT_W'(1));
			end else begin
				settling <= 1'b0;
			end
		end
	end

	// Conversion tracking; pins sampled while converting set the next pair
	always_ff @(posedge mclk) begin
		if (rst) begin
			convState <= adc_frontend_pkg::ST_IDLE;
			converting <= 1'b0;
			pendingPair <= 3'h0;
		end else begin
			case (convState)
				adc_frontend_pkg::ST_IDLE: begin
					if (convStart) begin
						convState <= adc_frontend_pkg::ST_CONVERT;
						converting <= 1'b1;
					end
				end
				adc_frontend_pkg::ST_CONVERT: begin
					pendingPair <= channelPairSelectPins; // [R11]
					if (convDone) begin
						convState <= adc_frontend_pkg::ST_IDLE;
						converting <= 1'b0;
					end
				end
				default: begin
					convState <= adc_frontend_pkg::ST_IDLE;
					converting <= 1'b0;
				end
			endcase
		end
	end

	// Mux selection; in hardware mode the first cycle after reset takes the pins as the start pair
	always_ff @(posedge mclk) begin
		if (rst) begin
			inReset <= 1'b1;
			muxA <= '0;
			muxB <= '0;
		end else begin
			inReset <= 1'b0;
			if (softNow) begin
				muxA.channel <= channelReg[adc_frontend_pkg::CH_A_LSB +: 3]; // [R13] [R16]
				muxB.channel <= channelReg[adc_frontend_pkg::CH_B_LSB +: 3]; // [R13] [R16]
				muxA.diag <= channelReg[adc_frontend_pkg::CH_DIAG_A_BIT]; // [R14]
				muxB.diag <= channelReg[adc_frontend_pkg::CH_DIAG_B_BIT]; // [R14]
				muxA.diagNode <= channelReg[adc_frontend_pkg::CH_A_LSB]; // [R14]
				muxB.diagNode <= channelReg[adc_frontend_pkg::CH_B_LSB]; // [R14]
			end else begin
				muxA.diag <= 1'b0; // [R12]
				muxB.diag <= 1'b0; // [R12]
				muxA.diagNode <= 1'b0;
				muxB.diagNode <= 1'b0;
				if (inReset) begin
					muxA.channel <= channelPairSelectPins; // [R10] [R16]
					muxB.channel <= channelPairSelectPins; // [R10] [R16]
				end else if (convState == adc_frontend_pkg::ST_CONVERT && convDone) begin
					muxA.channel <= pendingPair; // [R11] [R16]
					muxB.channel <= pendingPair; // [R11] [R16]
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- tb/adc_frontend_properties.sv
// Purpose: Port properties of the range and mux control.
// Assumes: One clock, synchronous reset.
// Notes: Pins are held steady across a conversion.
`timescale 1ns/1ps
`default_nettype none
module adc_frontend_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] rangeSelectPins,
	input wire logic [2:0] channelPairSelectPins,
	input wire logic convStart,
	input wire logic convDone,
	input wire adc_frontend_pkg::reg_req_t regReq,
	input wire logic regAck,
	input wire logic softwareMode,
	input wire adc_frontend_pkg::chan_range_t [7:0] groupARange,
	input wire adc_frontend_pkg::chan_range_t [7:0] groupBRange,
	input wire adc_frontend_pkg::filter_t filterOption,
	input wire adc_frontend_pkg::mux_sel_t muxA,
	input wire adc_frontend_pkg::mux_sel_t muxB,
	input wire logic settling,
	input wire logic converting
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	property p_ack;
		regReq.write || regReq.read |=> regAck;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_mode;
		rangeSelectPins == 2'b00 |=> softwareMode;
	endproperty
	a_mode: assert property (p_mode) else $error("no software mode");
	property p_ten;
		rangeSelectPins == 2'b11 |=> groupARange[0] == {1'b0, adc_frontend_pkg::RANGE_10V};
	endproperty
	a_ten: assert property (p_ten) else $error("bad 10V range");
	property p_low;
		rangeSelectPins == 2'b01 |=> groupBRange[7] == {1'b0, adc_frontend_pkg::RANGE_2V5};
	endproperty
	a_low: assert property (p_low) else $error("bad 2.5V range");
	property p_filt;
		rangeSelectPins != 2'b00 |=> filterOption == adc_frontend_pkg::FILTER_ONE;
	endproperty
	a_filt: assert property (p_filt) else $error("filter not fixed");
	property p_diag;
		rangeSelectPins != 2'b00 |=> !muxA.diag && !muxB.diag;
	endproperty
	a_diag: assert property (p_diag) else $error("diag in hw mode");
	property p_pair;
		convDone && converting && rangeSelectPins != 2'b00 |=>
			muxA.channel == $past(channelPairSelectPins, 2) && muxB.channel == muxA.channel;
	endproperty
	a_pair: assert property (p_pair) else $error("bad pair");
	property p_settle;
		$changed(rangeSelectPins) && filterOption == adc_frontend_pkg::FILTER_TWO |-> ##[1:2] settling;
	endproperty
	a_settle: assert property (p_settle) else $error("no settling");
	property p_conv;
		convStart && !converting |=> converting;
	endproperty
	a_conv: assert property (p_conv) else $error("no convert");
	c_settle: cover property (settling);
	c_done: cover property (convDone && converting);
	c_diag: cover property (softwareMode && muxA.diag);
endmodule
bind adc_frontend_range_mux_control adc_frontend_properties chk (.mclk, .rst, .rangeSelectPins,
	.channelPairSelectPins, .convStart, .convDone, .regReq, .regAck, .softwareMode,
	.groupARange, .groupBRange, .filterOption, .muxA, .muxB, .settling, .converting);
`default_nettype wire

//--- tb/host_model.sv
// Purpose: Host model issuing register cycles and conversions.
// Assumes: Device answers one cycle after a request.
// Notes: Idle bus lines carry an inverted pattern, not stale values.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic mclk,
	input wire logic [7:0] regRdata,
	input wire logic regAck,
	output adc_frontend_pkg::reg_req_t regReq,
	output logic convStart,
	output logic convDone
);
	initial begin
		regReq = '0;
		convStart = 1'b0;
		convDone = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regReq <= {2'b10, a, d};
		@(posedge mclk);
		regReq <= {2'b00, ~a, ~d};
	endtask
	// Both copies always get the same value
	task automatic wr2(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		wr(a + 8'h02, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ack);
		@(posedge mclk);
		regReq <= {2'b01, a, 8'h00};
		@(posedge mclk);
		regReq <= {2'b00, ~a, 8'hFF};
		#1;
		d = regRdata;
		ack = regAck;
	endtask
	task automatic conv(input int n);
		@(posedge mclk);
		convStart <= 1'b1;
		@(posedge mclk);
		convStart <= 1'b0;
		repeat (n) @(posedge mclk);
		convDone <= 1'b1;
		@(posedge mclk);
		convDone <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for range and mux control.
// Assumes: Host model runs register cycles; pins are driven here.
// Notes: A short settle count keeps the run brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	logic mclk, rst, convStart, convDone, regAck, softwareMode, ack;
	logic sequencerEnable, burstEnable, settling, converting;
	logic [1:0] rangeSelectPins;
	logic [2:0] channelPairSelectPins;
	logic [7:0] regRdata, d, a, b, cfg;
	logic [15:0] ra, rb;
	logic [31:0] seed = 32'h00002C5C;
	int num_errors = 0;
	int total_checks = 0;
	adc_frontend_pkg::reg_req_t regReq;
	adc_frontend_pkg::chan_range_t [7:0] groupARange, groupBRange;
	adc_frontend_pkg::filter_t filterOption;
	adc_frontend_pkg::mux_sel_t muxA, muxB;
	adc_frontend_range_mux_control #(.SETTLE_COUNT(8)) dut (.mclk, .rst, .rangeSelectPins,
		.channelPairSelectPins, .convStart, .convDone, .regReq, .regRdata, .regAck,
		.softwareMode, .groupARange, .groupBRange, .filterOption, .muxA, .muxB,
		.sequencerEnable, .burstEnable, .settling, .converting);
	host_model host (.mclk, .regRdata, .regAck, .regReq, .convStart, .convDone);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Register code 11 is unused and reads as the narrowest range
	function automatic adc_frontend_pkg::chan_range_t expRange(input logic [1:0] c, input logic o);
		return {o, (c == 2'b11) ? 2'b00 : c};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		rangeSelectPins = 2'b01;
		channelPairSelectPins = 3'h5;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		tick(2);
		`CHK(muxA.channel, 3'h5)
		`CHK(muxB.channel, 3'h5)
		for (int i = 1; i < 4; i++) begin
			@(posedge mclk);
			rangeSelectPins <= 2'(i);
			tick(2);
			for (int c = 0; c < 8; c++) begin
				`CHK(groupARange[c], expRange(2'(i - 1), 1'b0))
				`CHK(groupBRange[c], expRange(2'(i - 1), 1'b0))
			end
		end
		@(posedge mclk);
		rangeSelectPins <= 2'b00;
		for (int k = 0; k < 3; k++) begin
			ra = (k == 0) ? 16'hFFFF : 16'(xs());
			rb = 16'(xs());
			a = (k == 0) ? 8'hFF : 8'(xs());
			b = 8'(xs());
			host.wr(8'h04, ra[7:0]);
			host.wr(8'h06, ra[15:8]);
			host.wr(8'h05, rb[7:0]);
			host.wr(8'h07, rb[15:8]);
			host.wr2(8'h08, a);
			host.wr2(8'h09, b);
			tick(2);
			for (int c = 0; c < 8; c++) begin
				`CHK(groupARange[c], expRange(ra[2*c+:2], a[c]))
				`CHK(groupBRange[c], expRange(rb[2*c+:2], b[c]))
			end
			host.rd(8'h0A, d, ack);
			`CHK({ack, d}, {1'b1, a})
			host.rd(8'h0B, d, ack);
			`CHK({ack, d}, {1'b1, b})
		end
		host.rd(8'h0F, d, ack);
		`CHK({ack, d}, 9'h100)
		for (int f = 0; f < 3; f++) begin
			@(posedge mclk);
			rangeSelectPins <= 2'b00;
			cfg = {4'h0, 2'(xs()), 2'(f)};
			host.wr(8'h02, cfg);
			tick(2);
			`CHK(filterOption, adc_frontend_pkg::filter_t'(cfg[1:0]))
			`CHK(sequencerEnable, cfg[2])
			@(posedge mclk);
			rangeSelectPins <= 2'b10;
			tick(3);
			`CHK(settling, f == 1)
			`CHK(filterOption, adc_frontend_pkg::FILTER_ONE)
			`CHK(burstEnable, cfg[3])
			// Status: settling bit only; hardware mode forces filter one and no soft mode
			host.rd(8'h0C, d, ack);
			`CHK({ack, d}, (f == 1) ? 9'h104 : 9'h100)
			tick(12);
			`CHK(settling, 1'b0)
		end
		@(posedge mclk);
		rangeSelectPins <= 2'b00;
		for (int k = 0; k < 3; k++) begin
			cfg = (k == 0) ? 8'hE9 : 8'(xs());
			host.wr(8'h03, cfg);
			tick(2);
			`CHK({muxA.diag, muxA.channel}, cfg[3:0])
			`CHK({muxB.diag, muxB.channel}, cfg[7:4])
			if (k == 0) `CHK({muxA.diagNode, muxB.diagNode}, {cfg[0], cfg[4]})
		end
		@(posedge mclk);
		rangeSelectPins <= 2'b11;
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			channelPairSelectPins <= 3'(xs());
			host.conv(2 + k);
			tick(1);
			`CHK({muxA.diag, muxA.channel}, {1'b0, channelPairSelectPins})
			`CHK({muxB.diag, muxB.channel}, {1'b0, channelPairSelectPins})
		end
		give_verdict();
	end
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
